// file: core/sscc_pkg.sv
/*
 * Shared constants and types for the simultaneous sample conversion
 * control block: channel layout, timing counts, pin and result carriers.
 * Assumes a single 20 MHz clock domain and synchronous reset.
 */
package sscc_pkg;

	// channel layout
	localparam int NCH       = 4;
	localparam int CODE_W    = 16;
	localparam int AIN_W     = 19;  // unit: half a narrow-span step
	localparam int PAIR_SIZE = 2;

	// quantiser field positions: shift per span (narrow 1, wide 2)
	localparam int SHIFT_NARROW = 1;
	localparam int SHIFT_WIDE   = 2;

	// saturation limits of the signed code, at quantiser width
	localparam logic signed [AIN_W:0] CODE_MAX = 20'sh0_7fff;
	localparam logic signed [AIN_W:0] CODE_MIN = 20'shf_8000;

	// timing: conversion must finish within this time (round down)
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_TIME_NS  = 2000;
	localparam int CONV_CYC_RAW  = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CONV_CYC      = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
	localparam int CNT_W         = 6;
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);

	// values after reset
	localparam logic [CNT_W-1:0]  RST_CNT  = 6'h00;
	localparam logic [CODE_W-1:0] RST_CODE = 16'h0000;

	// carriers
	typedef logic signed [CODE_W-1:0] sscc_code_type;
	typedef logic signed [AIN_W-1:0]  sscc_ain_type;

	typedef struct packed {
		sscc_code_type [NCH-1:0] ch;
	} sscc_result_type;

	typedef struct packed {
		sscc_ain_type [NCH-1:0] ch;
	} sscc_inputs_type;

	typedef struct packed {
		logic sample_trigger_first_pair;
		logic sample_trigger_second_pair;
		logic span_wide;
		logic ref_internal;
	} sscc_pins_type;

	typedef enum logic [2:0] {
		SSCC_ST_TRACK = 3'h1,
		SSCC_ST_PART  = 3'h2,
		SSCC_ST_CONV  = 3'h4
	} sscc_state_type;

endpackage

// file: core/sscc_quant.sv
/*
 * One channel quantiser: held input to signed twos-complement code.
 * Assumes input in half narrow-span steps; purely combinational.
 */
`timescale 1ns/1ps
module sscc_quant (
	// held sample and span
	input  wire sscc_pkg::sscc_ain_type  ain_i,
	input  wire logic                    span_wide_i,
	// result
	output      sscc_pkg::sscc_code_type code_o
);
	import sscc_pkg::*;

	logic signed [AIN_W:0] ext_w;
	logic signed [AIN_W:0] biased_w;
	logic signed [AIN_W:0] scaled_w;

	// add half a step so transitions sit midway between codes
	always_comb begin
		ext_w    = {ain_i[AIN_W-1], ain_i};
		biased_w = span_wide_i ? (ext_w + 20'sh0_0002)
		                       : (ext_w + 20'sh0_0001);
		scaled_w = span_wide_i ? (biased_w >>> SHIFT_WIDE)
		                       : (biased_w >>> SHIFT_NARROW);
	end

	// clamp beyond full scale, then keep the signed code bits
	always_comb begin
		if (scaled_w > CODE_MAX) begin
			code_o = CODE_MAX[CODE_W-1:0];
		end else if (scaled_w < CODE_MIN) begin
			code_o = CODE_MIN[CODE_W-1:0];
		end else begin
			code_o = scaled_w[CODE_W-1:0];
		end
	end

endmodule

// file: core/sscc_ctrl.sv
/*
 * Conversion control of a four-channel simultaneous-sampling converter:
 * pin synchronisers, track-and-hold per pair, busy timing, result register.
 * Assumes a host drives triggers and configuration pins asynchronously,
 * one 20 MHz clock, synchronous active-high reset, clock enable ce_i.
 */
// Summary of operation
// [RULE1] span pin high selects wide bipolar span, low the narrow one
// [RULE2] span change acts at once; host allows settling before sampling
// [RULE3] host pulses reset after power-up so the span is latched; the code latches nothing, the span follows its pin whenever ce_i is high
// [RULE4] trigger rising edge puts its track-and-hold stages into hold
// [RULE5] conversion clock internal; all channels done within 2 us
// [RULE6] busy falls after all four conversions; stages return to track
// [RULE7] results update when busy falls; old results stay while busy
// [RULE8] every result is a signed twos-complement word
// [RULE9] step is span over 65536; transitions midway between steps
// [RULE10] reference pin high enables internal reference, low disables it
// [RULE11] after reset the reference mode follows the select pin
// [RULE12] first trigger holds channels 0 and 1, second holds 2 and 3
// [RULE13] conversion starts after both edges; busy rises on the later
// [RULE14] every channel is converted and reported, used or not
// [RULE15] trigger edges during busy are ignored
`timescale 1ns/1ps
module sscc_ctrl (
	// clock, reset, enable
	input  wire logic                      clk_i,
	input  wire logic                      srst_i,
	input  wire logic                      ce_i,
	// asynchronous pins and analog inputs
	input  wire sscc_pkg::sscc_pins_type   pins_i,
	input  wire sscc_pkg::sscc_inputs_type ain_i,
	// status and results
	output      logic                      busy_o,
	output      logic [3:0]                hold_o,
	output      logic                      span_wide_o,
	output      logic                      int_ref_en_o,
	output      sscc_pkg::sscc_result_type result_o
);
	import sscc_pkg::*;

	sscc_pins_type   sync1_r;
	sscc_pins_type   sync2_r;
	sscc_pins_type   sync3_r;
	sscc_pins_type   pin_filt_r;
	sscc_pins_type   pin_prev_r;
	sscc_state_type  state_r;
	sscc_state_type  state_nxt;
	logic [1:0]      seen_r;
	logic [1:0]      seen_nxt;
	logic [CNT_W-1:0] conv_cnt_r;
	logic            edge_first_w;
	logic            edge_second_w;
	logic            conv_done_w;
	logic [1:0]      grab_w;
	sscc_inputs_type held_r;
	sscc_result_type code_w;

	// three-stage synchroniser; stage one feeds only stage two
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end else if (ce_i) begin
			sync1_r <= pins_i;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// a change counts once stages two and three agree (glitch filter)
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_filt_r <= '0;
			pin_prev_r <= '0;
		end else if (ce_i) begin
			pin_filt_r <= (sync2_r == sync3_r) ? sync3_r : pin_filt_r;
			pin_prev_r <= pin_filt_r;
		end
	end

	// rising edges of the two sample triggers
	assign edge_first_w  = pin_filt_r.sample_trigger_first_pair &
	                       ~pin_prev_r.sample_trigger_first_pair;
	assign edge_second_w = pin_filt_r.sample_trigger_second_pair &
	                       ~pin_prev_r.sample_trigger_second_pair;
	assign conv_done_w   = (state_r == SSCC_ST_CONV) &&
	                       (conv_cnt_r == CONV_LAST);

	// span and reference follow the filtered pins; reset clears them to 0
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			span_wide_o  <= 1'b0;
			int_ref_en_o <= 1'b0;
		end else if (ce_i) begin
			span_wide_o  <= pin_filt_r.span_wide;   // [RULE1] [RULE3]
			int_ref_en_o <= pin_filt_r.ref_internal; // [RULE10] [RULE11]
		end
	end

	// sequencer: edges during conversion reach this logic but SSCC_ST_CONV ignores them
	always_comb begin
		state_nxt = state_r;
		seen_nxt  = seen_r;
		grab_w    = 2'b00;
		case (state_r)
			SSCC_ST_TRACK, SSCC_ST_PART: begin
				grab_w[0] = edge_first_w & ~seen_r[0];  // [RULE12]
				grab_w[1] = edge_second_w & ~seen_r[1]; // [RULE12]
				seen_nxt  = seen_r | grab_w;
				if (seen_nxt == 2'b11) begin
					state_nxt = SSCC_ST_CONV;           // [RULE13]
				end else if (seen_nxt != 2'b00) begin
					state_nxt = SSCC_ST_PART;
				end
			end
			SSCC_ST_CONV: begin
				if (conv_done_w) begin                  // [RULE15]
					state_nxt = SSCC_ST_TRACK;
					seen_nxt  = 2'b00;
				end
			end
			default: begin
				state_nxt = SSCC_ST_TRACK;
				seen_nxt  = 2'b00;
			end
		endcase
	end

	// state, busy and the pair-seen flags
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r <= SSCC_ST_TRACK;
			seen_r  <= 2'b00;
			busy_o  <= 1'b0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			seen_r  <= seen_nxt;
			busy_o  <= (state_nxt == SSCC_ST_CONV); // [RULE13] [RULE6]
		end
	end

	// internal conversion timer, a fixed count of clock cycles
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			conv_cnt_r <= RST_CNT;
		end else if (ce_i) begin
			if (state_r != SSCC_ST_CONV || conv_done_w) begin
				conv_cnt_r <= RST_CNT;
			end else begin
				conv_cnt_r <= conv_cnt_r + 6'h01;    // [RULE5]
			end
		end
	end

	// per channel: hold, quantise and register the result
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			localparam int PAIR = gi / PAIR_SIZE;

			// sample captured on its pair's edge, held until busy falls
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					held_r.ch[gi] <= '0;
					hold_o[gi]    <= 1'b0;
				end else if (ce_i) begin
					if (grab_w[PAIR]) begin
						held_r.ch[gi] <= ain_i.ch[gi]; // [RULE4]
						hold_o[gi]    <= 1'b1;         // [RULE4]
					end else if (conv_done_w) begin
						hold_o[gi]    <= 1'b0;         // [RULE6]
					end
				end
			end

			sscc_quant u_quant (
				.ain_i       (held_r.ch[gi]),
				.span_wide_i (span_wide_o),
				.code_o      (code_w.ch[gi])           // [RULE8] [RULE9]
			);

			// old codes stay readable for the whole conversion
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					result_o.ch[gi] <= RST_CODE;
				end else if (ce_i && conv_done_w) begin
					result_o.ch[gi] <= code_w.ch[gi];  // [RULE7] [RULE14]
				end
			end
		end
	endgenerate

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	span_follow_a: assert property ( // [RULE1]
		ce_i |=> span_wide_o == $past(pin_filt_r.span_wide))
		else $error("span output does not follow the span pin");

	ref_follow_a: assert property ( // [RULE10]
		ce_i |=> int_ref_en_o == $past(pin_filt_r.ref_internal))
		else $error("reference enable does not follow select pin");

	first_hold_a: assert property ( // [RULE4]
		ce_i && state_r == SSCC_ST_TRACK && edge_first_w
		|=> hold_o[1:0] == 2'b11)
		else $error("first pair not held after its trigger edge");

	pair_split_a: assert property ( // [RULE12]
		ce_i && state_r == SSCC_ST_TRACK && edge_second_w && !edge_first_w
		|=> hold_o == 4'b1100 && !busy_o)
		else $error("second trigger held the wrong channels");

	busy_late_a: assert property ( // [RULE13]
		ce_i && state_r == SSCC_ST_PART && !edge_first_w && !edge_second_w
		|=> !busy_o ##0 hold_o != 4'b0000)
		else $error("busy rose before both trigger edges");

	conv_time_a: assert property ( // [RULE5]
		$fell(busy_o) |-> $past(conv_cnt_r) == CONV_LAST)
		else $error("conversion did not last the fixed time");

	track_return_a: assert property ( // [RULE6]
		$fell(busy_o) |-> hold_o == 4'b0000)
		else $error("stages not back in track when busy fell");

	result_keep_a: assert property ( // [RULE7]
		busy_o && $past(busy_o) |-> $stable(result_o))
		else $error("results changed during a conversion");

	result_load_a: assert property ( // [RULE8] [RULE9] [RULE14]
		$fell(busy_o) |-> result_o == $past(code_w))
		else $error("results not loaded from all channels");

	busy_ignore_a: assert property ( // [RULE15]
		busy_o && ce_i && conv_cnt_r != CONV_LAST
		|=> busy_o && $stable(hold_o) && $stable(held_r))
		else $error("trigger edge disturbed a running conversion");

endmodule

// file: bench/sscc_host_model.sv
/*
 * Host-side partner: drives trigger and strap pins of the converter.
 * Assumes clk_i is the converter clock; pins change 2 ns after an edge.
 */
`timescale 1ns/1ps
module sscc_host_model (
	// clock
	input  wire logic               clk_i,
	// pins toward the converter
	output sscc_pkg::sscc_pins_type pins_o
);
	import sscc_pkg::*;

	// straps start low; the bench pulses reset after power-up
	initial pins_o = '0;

	// span or reference change; caller waits before sampling
	task automatic set_cfg(input logic span, input logic refi);
		@(posedge clk_i);
		#2;
		pins_o.span_wide    = span;
		pins_o.ref_internal = refi;
	endtask

	// pulse held 6 edges so it survives the synchroniser and filter
	task automatic pulse(input logic a, input logic b);
		@(posedge clk_i);
		#2;
		pins_o.sample_trigger_first_pair  = a;
		pins_o.sample_trigger_second_pair = b;
		repeat (6) @(posedge clk_i);
		#2;
		pins_o.sample_trigger_first_pair  = 1'b0;
		pins_o.sample_trigger_second_pair = 1'b0;
	endtask
endmodule

// file: bench/sscc_ctrl_tb_top.sv
/*
 * Self-checking bench for the conversion control block.
 * Assumes the host model drives pins; ain and reset come from here.
 */
`timescale 1ns/1ps
module sscc_ctrl_tb_top;
	import sscc_pkg::*;

	// stimulus and observed signals
	logic            clk_i  = 1'b0;
	logic            srst_i = 1'b1;
	logic            ce_i   = 1'b1;
	sscc_pins_type   pins;
	sscc_inputs_type ain    = '0;
	logic            busy;
	logic [3:0]      hold;
	logic            span_wide;
	logic            int_ref_en;
	sscc_result_type result;
	sscc_result_type exp_res;
	sscc_result_type old_res;
	int              n_fail = 0;
	int              total_checks = 0;
	int              seed = 32'h9339_ab97;
	int              k;
	int              n;

	// 20 MHz clock
	always #25 clk_i = ~clk_i;

	sscc_host_model u_sscc_host_model (.clk_i(clk_i), .pins_o(pins));
	sscc_ctrl u_sscc_ctrl (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
		.pins_i(pins), .ain_i(ain), .busy_o(busy), .hold_o(hold),
		.span_wide_o(span_wide), .int_ref_en_o(int_ref_en),
		.result_o(result));

	// ideal quantiser: half-step rounding, saturated to 16 bits
	function automatic sscc_code_type quant(input sscc_ain_type x,
		input logic w);
		int v;
		v = w ? ((int'(x) + 2) >>> 2) : ((int'(x) + 1) >>> 1);
		if (v > 32767) v = 32767;
		if (v < -32768) v = -32768;
		return v[15:0];
	endfunction

	task automatic tick(input int c);
		repeat (c) @(posedge clk_i);
		#2;
	endtask

	task automatic cmp_bits(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_res(input sscc_result_type got,
		input sscc_result_type exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one sample sequence; refire pulses triggers again while busy
	task automatic conv(input logic a_first, input logic split,
		input logic refire);
		int c;
		c = 0;
		old_res = result;
		// span taken from the pin the host drove, not from the design
		for (k = 0; k < NCH; k++)
			exp_res.ch[k] = quant(ain.ch[k], pins.span_wide);
		if (split) begin
			u_sscc_host_model.pulse(a_first, !a_first);
			tick(4);
			cmp_bits(16'(busy), 16'h0000);
			cmp_bits(16'(hold), a_first ? 16'h0003 : 16'h000c);
			u_sscc_host_model.pulse(!a_first, a_first);
		end else begin
			u_sscc_host_model.pulse(1'b1, 1'b1);
		end
		cmp_bits(16'(hold), 16'h000f);
		cmp_bits(16'(busy), 16'h0001);
		// gap so the filter sees a fresh edge; new inputs must not be taken
		if (refire) begin
			tick(3);
			ain = ~ain;
			u_sscc_host_model.pulse(1'b1, 1'b1);
			c = 10;
		end
		while (busy === 1'b1 && c < 80) begin
			cmp_res(result, old_res);
			tick(1);
			c++;
		end
		cmp_bits(16'(c + 1), 16'(CONV_CYC));
		cmp_bits(16'(hold), 16'h0000);
		cmp_res(result, exp_res);
		tick(8);
		cmp_bits(16'({busy, hold}), 16'h0000);
	endtask

	task automatic summarize;
		$display("checks %0d, failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// main sequence: config, random and corner conversions, reset
	initial begin
		tick(2);
		srst_i = 1'b0;
		cmp_res(result, '0);
		for (k = 0; k < 4; k++) begin
			u_sscc_host_model.set_cfg(k[1], k[0]);
			tick(7);
			cmp_bits(16'(span_wide), 16'(k[1]));
			cmp_bits(16'(int_ref_en), 16'(k[0]));
		end
		for (n = 0; n < 8; n++) begin
			for (k = 0; k < NCH; k++) ain.ch[k] = sscc_ain_type'($random(seed));
			u_sscc_host_model.set_cfg(n[0], 1'b1);
			tick(7);
			conv(n[1], n[2], n == 3);
		end
		// saturation and rounding corners, both spans
		ain.ch[0] = 19'h3_ffff;
		ain.ch[1] = 19'h4_0000;
		ain.ch[2] = 19'h0_0001;
		ain.ch[3] = 19'h7_ffff;
		conv(1'b0, 1'b0, 1'b0);
		u_sscc_host_model.set_cfg(1'b0, 1'b1);
		tick(7);
		conv(1'b1, 1'b1, 1'b0);
		// clock enable low freezes the pin path
		u_sscc_host_model.set_cfg(1'b1, 1'b1);
		ce_i = 1'b0;
		tick(10);
		cmp_bits(16'(span_wide), 16'h0000);
		ce_i = 1'b1;
		tick(7);
		cmp_bits(16'(span_wide), 16'h0001);
		// mid-run reset: reference mode reloads from its pin
		srst_i = 1'b1;
		tick(2);
		cmp_bits(16'(int_ref_en), 16'h0000);
		cmp_res(result, '0);
		srst_i = 1'b0;
		tick(7);
		cmp_bits(16'(int_ref_en), 16'h0001);
		summarize;
	end

	// watchdog, far beyond the expected run of about 730 cycles
	initial begin
		#250000;
		n_fail++;
		summarize;
	end
endmodule
